// [rtl/kwu_key_wakeup.sv]
// Purpose: Key wakeup release logic with an AXI4-Lite register slave
// Assumes: Halt entry request comes from the system control block
// Notes:   Pins pass three flops; a change counts when stages 2 and 3 agree
`timescale 1ns/1ps
`include "kwu_regs.svh"

module kwu_key_wakeup #(
    parameter int NUM_PINS = 8,
    parameter int ADDR_W   = 16
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Pins
    input  wire logic                release_pin,
    input  wire logic [NUM_PINS-1:0] wake_pin,
    output logic [NUM_PINS-1:0]      wake_pin_pullup,
    // System control side
    input  wire logic                halt_enter,
    input  wire logic                release_mode_select,
    output kwu_pkg::kwu_halt_out_t   halt_out
);

    import kwu_pkg::*;

    localparam int SYNC_W = NUM_PINS + 1;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0]              wake_ctrl_pins_low_reg;
    logic [7:0]              wake_ctrl_pins_high_reg;
    logic [NUM_PINS-1:0]     port_pullup_control_reg;
    logic [SYNC_W-1:0]       sync1_reg;
    logic [SYNC_W-1:0]       sync2_reg;
    logic [SYNC_W-1:0]       sync3_reg;
    logic [SYNC_W-1:0]       pins_reg;
    logic                    release_pin_prev_reg;
    kwu_state_t              state_reg;
    kwu_halt_out_t           halt_out_reg;

    logic                    awready_reg;
    logic                    wready_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    arready_reg;
    logic                    rvalid_reg;
    logic [1:0]              rresp_reg;
    logic [31:0]             rdata_reg;
    logic [ADDR_W-1:0]       waddr_reg;
    logic [31:0]             wdata_reg;
    logic                    wstb_reg;

    // ------------------------------------------------------------
    // Combinational views
    // ------------------------------------------------------------
    logic [2*NUM_PINS-1:0]   ctrl_all;
    logic [NUM_PINS-1:0]     pin_enable;
    logic [NUM_PINS-1:0]     pin_level;
    logic [NUM_PINS-1:0]     key_hit;
    logic                    rel_pin_f;
    logic [NUM_PINS-1:0]     wake_f;
    logic                    level_release;
    logic                    edge_release;
    logic                    release_cond;
    kwu_status_t             status;
    logic                    do_write;
    logic                    aw_take;
    logic                    w_take;
    logic                    ar_take;

    assign ctrl_all  = (2*NUM_PINS)'({wake_ctrl_pins_high_reg,
                                      wake_ctrl_pins_low_reg});
    assign rel_pin_f = pins_reg[NUM_PINS];
    assign wake_f    = pins_reg[NUM_PINS-1:0];

    // Per pin fields: enable at the even bit, level at the odd bit
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            assign pin_enable[g] = ctrl_all[2*g + `KWU_EN_BIT];
            assign pin_level[g]  = ctrl_all[2*g + `KWU_LVL_BIT];
            // Pin must equal its selected release level
            assign key_hit[g] = pin_enable[g]
                              & (wake_f[g] == pin_level[g]);
        end
    endgenerate

    // Release pin is never gated by any enable
    assign level_release = rel_pin_f | (|key_hit);
    // Edge mode: key pins sit at their level after entry, so only a
    // rising edge of the release pin can end the halt there
    assign edge_release  = rel_pin_f & ~release_pin_prev_reg;
    assign release_cond  = release_mode_select ? level_release
                                               : edge_release;

    assign status.release_cond = release_cond;
    assign status.halted       = (state_reg == KWU_HALT);
    assign status.release_pin  = rel_pin_f;
    assign status.wake_pin     = wake_f;

    assign aw_take  = s_axi_awvalid & awready_reg;
    assign w_take   = s_axi_wvalid & wready_reg;
    assign ar_take  = s_axi_arvalid & arready_reg;
    assign do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pins come from outside, so three stages before use
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= SYNC_W'(`KWU_SYNC_RESET);
            sync2_reg <= SYNC_W'(`KWU_SYNC_RESET);
            sync3_reg <= SYNC_W'(`KWU_SYNC_RESET);
        end else begin
            sync1_reg <= {release_pin, wake_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A bit changes only where stages 2 and 3 agree, which rejects
    // single-cycle glitches at the cost of one more cycle of latency
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins_reg <= SYNC_W'(`KWU_SYNC_RESET);
        end else begin
            pins_reg <= (sync2_reg & sync3_reg)
                      | (pins_reg & (sync2_reg | sync3_reg));
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            release_pin_prev_reg <= 1'b0;
        end else begin
            release_pin_prev_reg <= rel_pin_f;
        end
    end

    // ------------------------------------------------------------
    // Halt sequencing
    // ------------------------------------------------------------
    // Release is judged on the running clock after the pin filter, so
    // a key must hold its level for two cycles before it is seen
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= KWU_RUN;
            halt_out_reg <= '0;
        end else begin
            halt_out_reg.release_req <= 1'b0;
            halt_out_reg.halt_skip   <= 1'b0;
            case (state_reg)
                KWU_RUN: begin
                    if (halt_enter) begin
                        if (release_cond) begin
                            // Already released: no halt, no warm-up
                            halt_out_reg.halt_skip <= 1'b1;
                        end else begin
                            state_reg                <= KWU_HALT;
                            halt_out_reg.halt_active <= 1'b1;
                        end
                    end
                end
                KWU_HALT: begin
                    if (release_cond) begin
                        state_reg                <= KWU_RUN;
                        halt_out_reg.halt_active <= 1'b0;
                        halt_out_reg.release_req <= 1'b1;
                    end
                end
                default: begin
                    state_reg                <= KWU_RUN;
                    halt_out_reg.halt_active <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data may arrive in either order; each is held
    // until both are present and the response is accepted
    // Only one write is open at a time: the next address waits for
    // the response handshake, which keeps the decode simple
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awready_reg <= 1'b1;
            waddr_reg   <= '0;
        end else if (aw_take) begin
            awready_reg <= 1'b0;
            waddr_reg   <= s_axi_awaddr;
        end else if (bvalid_reg && s_axi_bready) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wready_reg <= 1'b1;
            wdata_reg  <= '0;
            wstb_reg   <= 1'b0;
        end else if (w_take) begin
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata;
            wstb_reg   <= s_axi_wstrb[`KWU_STB_LANE];
        end else if (bvalid_reg && s_axi_bready) begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `KWU_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= addr_hit(waddr_reg) ? `KWU_RESP_OKAY
                                              : `KWU_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Control registers; lane 0 carries the 8-bit fields
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wake_ctrl_pins_low_reg  <= `KWU_CTRL_RESET;
            wake_ctrl_pins_high_reg <= `KWU_CTRL_RESET;
        end else if (do_write && wstb_reg) begin
            if (addr_is(waddr_reg, `KWU_IDX_CTRL_LOW)) begin
                wake_ctrl_pins_low_reg <= wdata_reg[7:0];
            end
            if (addr_is(waddr_reg, `KWU_IDX_CTRL_HIGH)) begin
                wake_ctrl_pins_high_reg <= wdata_reg[7:0];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            port_pullup_control_reg <= NUM_PINS'(`KWU_PULLUP_RESET);
        end else if (do_write && wstb_reg
                     && addr_is(waddr_reg, `KWU_IDX_PULLUP)) begin
            port_pullup_control_reg <= wdata_reg[NUM_PINS-1:0];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    // Data is captured at the address edge so it stands unchanged
    // while rvalid waits for rready
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `KWU_RESP_OKAY;
            rdata_reg   <= '0;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= addr_hit(s_axi_araddr) ? `KWU_RESP_OKAY
                                                  : `KWU_RESP_SLVERR;
            rdata_reg   <= read_mux(s_axi_araddr);
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Index times four gives the byte address of each word
    // Status word is read only: a write to it is answered OKAY and
    // changes nothing
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [`KWU_IDX_W-1:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        return a == byte_addr;
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return addr_is(a, `KWU_IDX_CTRL_LOW)
             | addr_is(a, `KWU_IDX_CTRL_HIGH)
             | addr_is(a, `KWU_IDX_PULLUP)
             | addr_is(a, `KWU_IDX_STATUS);
    endfunction

    // Unused upper bits read as zero; unmapped words read zero
    function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        d = '0;
        if (addr_is(a, `KWU_IDX_CTRL_LOW)) begin
            d = 32'(wake_ctrl_pins_low_reg);
        end
        if (addr_is(a, `KWU_IDX_CTRL_HIGH)) begin
            d = 32'(wake_ctrl_pins_high_reg);
        end
        if (addr_is(a, `KWU_IDX_PULLUP)) begin
            d = 32'(port_pullup_control_reg);
        end
        if (addr_is(a, `KWU_IDX_STATUS)) begin
            d = 32'(status);
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from its register
    assign s_axi_awready   = awready_reg;
    assign s_axi_wready    = wready_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = arready_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rresp     = rresp_reg;
    assign s_axi_rdata     = rdata_reg;
    assign wake_pin_pullup = port_pullup_control_reg;
    assign halt_out        = halt_out_reg;

endmodule // kwu_key_wakeup

// [rtl/kwu_regs.svh]
// Purpose: Register map and constants of the key wakeup block
// Assumes: Included by the key wakeup top module
// Notes:   Byte address of a register is four times its index
`ifndef KWU_REGS_SVH
`define KWU_REGS_SVH

`define KWU_IDX_CTRL_LOW   12'hFC4
`define KWU_IDX_CTRL_HIGH  12'hFC5
`define KWU_IDX_PULLUP     12'hFC6
`define KWU_IDX_STATUS     12'hFC7
`define KWU_IDX_W          12
`define KWU_CTRL_RESET     8'h00
`define KWU_PULLUP_RESET   8'h00
`define KWU_PINS_PER_REG   4
`define KWU_EN_BIT         0
`define KWU_LVL_BIT        1
`define KWU_SYNC_RESET     9'h000
`define KWU_RESP_OKAY      2'h0
`define KWU_RESP_SLVERR    2'h2
`define KWU_STB_LANE       0

`endif

// [rtl/kwu_pkg.sv]
// Purpose: Types shared by the key wakeup block
// Assumes: Constants come from kwu_regs.svh
// Notes:   One-hot state codes are written out
package kwu_pkg;

    typedef enum logic [1:0] {
        KWU_RUN  = 2'h1,
        KWU_HALT = 2'h2
    } kwu_state_t;

    // Snapshot of the block as software reads it
    typedef struct packed {
        logic       release_cond;
        logic       halted;
        logic       release_pin;
        logic [7:0] wake_pin;
    } kwu_status_t;

    // Halt side signals towards the clock controller
    typedef struct packed {
        logic release_req;
        logic halt_skip;
        logic halt_active;
    } kwu_halt_out_t;

endpackage

// [sim/kwu_keys.sv]
// Purpose: Keys and switches standing on the wake pins
// Assumes: Bench picks which keys drive and at what level
// Notes:   An open pin with no pull-up toggles, so it never looks firm
`timescale 1ns/1ps

module kwu_keys (
    input  wire logic       clock,
    input  wire logic [7:0] key_oe,
    input  wire logic [7:0] key_lvl,
    input  wire logic       stop_lvl,
    input  wire logic [7:0] pull_en,
    output logic [7:0]      wake_pin,
    output logic            release_pin
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    logic [7:0] float_pat = 8'h55;

    always @(posedge clock) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wake_pin[i] = key_oe[i] ? key_lvl[i]
                        : (pull_en[i] ? 1'h1 : float_pat[i]);
        end
    end

    // Switch holds the pin low whenever only keys should release
    assign release_pin = stop_lvl;
endmodule // kwu_keys

// [sim/kwu_asserts.sv]
// Purpose: Port-level checks of the key wakeup block
// Assumes: Bench keeps pins stable for several cycles around changes
// Notes:   Release windows allow slack for the pin synchroniser
`timescale 1ns/1ps

module kwu_asserts #(
    parameter int NUM_PINS = 8
) (
    input wire logic                   clock,
    input wire logic                   nrst,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic                   release_pin,
    input wire logic [NUM_PINS-1:0]    wake_pin_pullup,
    input wire logic                   halt_enter,
    input wire kwu_pkg::kwu_halt_out_t halt_out
);
    import kwu_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Halt handshake
    // ------------------------------------------------------------
    enter_answer_a: assert property (halt_enter &&
        !halt_out.halt_active |=> halt_out.halt_active != halt_out.halt_skip)
        else $error("halt entry not answered");
    skip_cause_a: assert property (halt_out.halt_skip |->
        $past(halt_enter) && !halt_out.halt_active) else $error("bad skip");
    req_ends_a: assert property (halt_out.release_req |->
        !halt_out.halt_active && $past(halt_out.halt_active))
        else $error("release without halt");
    fall_req_a: assert property ($fell(halt_out.halt_active) |->
        halt_out.release_req) else $error("halt ended silently");
    req_pulse_a: assert property (halt_out.release_req |=>
        !halt_out.release_req) else $error("release not a pulse");
    pin_release_a: assert property (halt_out.halt_active &&
        $rose(release_pin) ##1 release_pin [*6] |-> !halt_out.halt_active)
        else $error("release pin ignored");
    pullup_write_a: assert property ($changed(wake_pin_pullup) |->
        $rose(s_axi_bvalid)) else $error("pull-up changed without write");
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
endmodule // kwu_asserts

bind kwu_key_wakeup kwu_asserts #(.NUM_PINS(NUM_PINS)) kwu_asserts_inst (
    .clock, .nrst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .release_pin, .wake_pin_pullup, .halt_enter, .halt_out);

// [sim/tb_kwu_key_wakeup.sv]
// Purpose: Self-checking bench of the key wakeup block
// Assumes: Register byte address is four times the index
// Notes:   Pins settle five cycles before a halt is requested
`timescale 1ns/1ps

module tb_kwu_key_wakeup;
    import kwu_pkg::*;
    // ------------------------------------------------------------
    // Signals and parts
    // ------------------------------------------------------------
    localparam logic [15:0] A_LO = 16'h3F10, A_HI = 16'h3F14;
    localparam logic [15:0] A_PU = 16'h3F18, A_ST = 16'h3F1C;
    localparam logic [15:0] A_BAD = 16'h3F20;
    logic          clock = 1'h0, nrst = 1'h0;
    logic [15:0]   s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]    s_axi_wstrb = 4'h0;
    logic          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic          s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic          s_axi_rready = 1'h0, halt_enter = 1'h0;
    logic          release_mode_select = 1'h1;
    logic          stop_lvl = 1'h0, release_pin;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic          s_axi_arready, s_axi_rvalid;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic [7:0]    wake_pin, wake_pin_pullup;
    logic [7:0]    key_oe = 8'hFF, key_lvl = 8'h00;
    kwu_halt_out_t halt_out;
    int            err_total = 0, checks = 0;

    kwu_key_wakeup kwu_key_wakeup_inst (.clock, .nrst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .release_pin, .wake_pin, .wake_pin_pullup, .halt_enter,
        .release_mode_select, .halt_out);
    kwu_keys kwu_keys_inst (.clock, .key_oe, .key_lvl, .stop_lvl,
        .pull_en(wake_pin_pullup), .wake_pin, .release_pin);

    initial begin
        forever #10 clock = ~clock;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic bound(input logic done);
        if (!done) begin
            chk(1'h0, "timeout");
            stop_test();
        end
    endtask
    task automatic axi_wr(input logic [15:0] a, input logic [7:0] d,
                          input logic [3:0] st, input logic [1:0] er);
        logic done;
        done = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                done = 1'h1;
                s_axi_bready <= 1'h0;
                chk(s_axi_bresp === er, "write response");
            end
        end
        bound(done);
        // One idle edge so a following call never re-raises bready here
        @(posedge clock);
    endtask
    task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        logic done;
        done = 1'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                done = 1'h1;
                s_axi_rready <= 1'h0;
                chk(s_axi_rdata === ed && s_axi_rresp === er, "read");
            end
        end
        bound(done);
        @(posedge clock);
    endtask
    task automatic enter_halt(output logic act, output logic skp);
        repeat (5) @(posedge clock);
        halt_enter <= 1'h1;
        @(posedge clock);
        halt_enter <= 1'h0;
        @(posedge clock);
        act = halt_out.halt_active;
        skp = halt_out.halt_skip;
    endtask
    task automatic wait_rel(input int lim, output logic got);
        got = 1'h0;
        for (int i = 0; i < lim; i++) begin
            @(posedge clock);
            if (halt_out.release_req === 1'h1) got = 1'h1;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        axi_rd(A_LO, 32'h0, 2'h0);
        axi_rd(A_HI, 32'h0, 2'h0);
        axi_rd(A_PU, 32'h0, 2'h0);
        chk(wake_pin_pullup === 8'h00, "pull-up reset");
        axi_rd(A_BAD, 32'h0, 2'h2);
    endtask
    task automatic t_stop_pin();
        logic act, skp, got;
        enter_halt(act, skp);
        chk(act === 1'h1 && skp === 1'h0, "halt at reset");
        key_lvl <= 8'hFF;
        wait_rel(10, got);
        chk(got === 1'h0 && halt_out.halt_active === 1'h1, "key");
        stop_lvl <= 1'h1;
        wait_rel(8, got);
        chk(got === 1'h1 && halt_out.halt_active === 1'h0, "pin");
        stop_lvl <= 1'h0;
    endtask
    task automatic t_regs();
        axi_wr(A_LO, 8'h5A, 4'h1, 2'h0);
        axi_wr(A_HI, 8'hA5, 4'h1, 2'h0);
        axi_wr(A_LO, 8'hFF, 4'hE, 2'h0);
        axi_wr(A_BAD, 8'hFF, 4'h1, 2'h2);
        axi_rd(A_LO, 32'h5A, 2'h0);
        axi_rd(A_HI, 32'hA5, 2'h0);
        axi_wr(A_HI, 8'h00, 4'h1, 2'h0);
    endtask
    task automatic t_pullup();
        key_oe <= 8'hF0;
        key_lvl <= 8'h00;
        axi_wr(A_LO, 8'h00, 4'h1, 2'h0);
        axi_wr(A_PU, 8'h0F, 4'h1, 2'h0);
        chk(wake_pin_pullup === 8'h0F, "pull-up out");
        repeat (5) @(posedge clock);
        axi_rd(A_ST, 32'h0000000F, 2'h0);
        axi_wr(A_PU, 8'h00, 4'h1, 2'h0);
        key_oe <= 8'hFF;
    endtask
    task automatic t_keys();
        logic [15:0] a;
        logic act, skp, got;
        for (int m = 0; m < 8; m++) begin
            for (int lv = 0; lv < 2; lv++) begin
                a = (m < 4) ? A_LO : A_HI;
                key_lvl <= (lv == 1) ? 8'h00 : 8'hFF;
                axi_wr(a, 8'((1 + 2 * lv) << (2 * (m % 4))), 4'h1, 2'h0);
                enter_halt(act, skp);
                chk(act === 1'h1 && skp === 1'h0, "key halt");
                key_lvl[m] <= 1'(lv);
                wait_rel(8, got);
                chk(got === 1'h1, "key release");
                axi_wr(a, 8'h00, 4'h1, 2'h0);
            end
        end
    endtask
    task automatic t_skip();
        logic act, skp;
        key_lvl <= 8'h01;
        axi_wr(A_LO, 8'h03, 4'h1, 2'h0);
        enter_halt(act, skp);
        chk(skp === 1'h1 && act === 1'h0, "skip on key");
        axi_wr(A_LO, 8'h00, 4'h1, 2'h0);
        stop_lvl <= 1'h1;
        enter_halt(act, skp);
        chk(skp === 1'h1 && act === 1'h0, "skip on pin");
        stop_lvl <= 1'h0;
    endtask
    task automatic t_edge();
        logic act, skp, got;
        release_mode_select <= 1'h0;
        key_lvl <= 8'h00;
        axi_wr(A_LO, 8'h03, 4'h1, 2'h0);
        enter_halt(act, skp);
        key_lvl <= 8'h01;
        wait_rel(10, got);
        chk(act === 1'h1 && got === 1'h0, "edge mode key");
        stop_lvl <= 1'h1;
        wait_rel(8, got);
        chk(got === 1'h1, "edge mode pin");
        stop_lvl <= 1'h0;
        release_mode_select <= 1'h1;
    endtask

    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'h1;
        @(posedge clock);
        t_reset();
        t_stop_pin();
        t_regs();
        t_pullup();
        t_keys();
        t_skip();
        t_edge();
        stop_test();
    end
endmodule // tb_kwu_key_wakeup
